// >>> core/dmacs_defs.svh
/*
 Constants for the DMA channel control and status block: register offsets,
 field positions, reset values and counts. Assumes inclusion by bare name.
*/
// Behaviour
// - Normal priority drives AXI when panic low
// - Error bit reads one while debug errors
// - Waiting bit while drain mode holds block end for write responses
// - Stall bit when only pacing request blocks
// - Paused bit from enable, waits, halt, writes
// - Request bit mirrors selected pacing line
// - Request bit reads zero until first block load
// - Unpaced select reads request bit as one
// - Irq pending sticky, write one clears
// - Done flag on block end, write one clears
// - Start needs run enable and nonzero pointer
// - Run enable clear pauses, set resumes
// - Hardware clears run enable at chain end
// - Fetch control block before data transfer
// - Copy next link into pointer at end
// - Zero link stops, no more fetches
// - Pointer reads current block address
// - Panic priority drives AXI when panic high
// - Drain mode pauses above thirteen writes
// - Block info bit zero enables completion irq
`ifndef DMACS_DEFS_SVH
`define DMACS_DEFS_SVH
`define DMACS_OFS_CTRL      12'h000
`define DMACS_OFS_DESC      12'h004
`define DMACS_OFS_DEBUG     12'h00C
`define DMACS_OFS_INFO      12'h010
`define DMACS_OFS_NEXT      12'h014
`define DMACS_B_RUN         0
`define DMACS_B_DONE        1
`define DMACS_B_IRQ         2
`define DMACS_B_REQ         3
`define DMACS_B_PAUSED      4
`define DMACS_B_STALL       5
`define DMACS_B_WAITWR      6
`define DMACS_B_ERROR       8
`define DMACS_B_DRAIN       28
`define DMACS_CTRL_WMASK    32'h10FF0001
`define DMACS_INFO_IEN      0
`define DMACS_INFO_SRCREQ   10
`define DMACS_INFO_DSTREQ   6
`define DMACS_MAX_OUTS      5'h0D
`define DMACS_DESC_RESET    32'h00000000
`define DMACS_CB_WORDS      3'h7
`endif

// >>> core/dmacs_pkg.sv
/*
 Types for the DMA channel control and status block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dmacs_pkg;
   typedef enum logic [2:0] {
      DMACS_IDLE  = 3'b000,
      DMACS_FETCH = 3'b001,
      DMACS_XFER  = 3'b011,
      DMACS_DRAIN = 3'b010,
      DMACS_LINK  = 3'b110
   } dmacs_state_e;
endpackage

// >>> core/dmacs_top.sv
/*
 DMA channel control, status and descriptor pointer logic with an AXI4-Lite
 register slave, a simple descriptor fetch port and a data engine handshake.
 Assumes a data engine and memory read port on core_clk; peripheral request,
 panic and halt lines are asynchronous and are synchronised here.
*/
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "dmacs_defs.svh"
module dmacs_top
   import dmacs_pkg::*;
#(
   parameter int NPERIPH = 32
)
(
   input  wire logic               core_clk,
   input  wire logic               reset_n,
   input  wire logic [11:0]        s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [11:0]        s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   output logic                    cb_req,
   output logic [31:0]             descriptor_pointer,
   input  wire logic               cb_valid,
   input  wire logic [31:0]        cb_data,
   output logic                    xfer_go,
   input  wire logic               xfer_done,
   input  wire logic               xfer_waiting,
   input  wire logic               wr_issue,
   input  wire logic               wr_resp,
   input  wire logic [7:0]         dbg_err_set,
   input  wire logic [NPERIPH-1:0] peripheral_request_line,
   input  wire logic [NPERIPH-1:0] periph_panic,
   input  wire logic               debug_halt,
   output logic [3:0]              axi_qos,
   output logic [31:0]             cb_info_o
);
   logic [NPERIPH-1:0] req_s1_r;
   logic [NPERIPH-1:0] req_s2_r;
   logic [NPERIPH-1:0] pan_s1_r;
   logic [NPERIPH-1:0] pan_s2_r;
   logic               halt_s1_r;
   logic               halt_s2_r;
   logic [31:0]        ctrl_r;
   logic [31:0]        descriptor_pointer_r;
   logic [31:0]        info_r;
   logic [31:0]        next_descriptor_link_r;
   logic [7:0]         dbg_r;
   logic               done_r;
   logic               irq_r;
   logic               loaded_r;
   logic [4:0]         outs_r;
   logic [2:0]         widx_r;
   logic [2:0]         fetch_idx;
   dmacs_state_e       state_r;
   logic [11:0]        awaddr_r;
   logic [31:0]        wdata_r;
   logic               aw_have_r;
   logic               w_have_r;
   logic               wr_fire;
   logic               done_set;
   logic               irq_set;
   logic               chain_end;
   logic [4:0]         sel;
   logic               req_bit;
   logic               stall_bit;
   logic               paused_bit;
   logic               waitwr_bit;

   always_ff @(posedge core_clk)
   begin
      req_s1_r  <= peripheral_request_line;
      req_s2_r  <= req_s1_r;
      pan_s1_r  <= periph_panic;
      pan_s2_r  <= pan_s1_r;
      halt_s1_r <= debug_halt;
      halt_s2_r <= halt_s1_r;
   end

   // Word match that ignores the byte lane bits of the bus address
   function automatic logic word_is(input logic [11:0] a, input logic [11:0] ofs);
      word_is = (a[11:2] == ofs[11:2]);
   endfunction

   // AXI4-Lite write side: address and data accepted in either order
   assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         awaddr_r      <= 12'h000;
         wdata_r       <= 32'h00000000;
      end
      else
      begin
         s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                       {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
         end
         if (wr_fire)
         begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Read-only and unmapped words answer SLVERR and change nothing
            s_axi_bresp  <= (word_is(awaddr_r, `DMACS_OFS_CTRL) ||
                             word_is(awaddr_r, `DMACS_OFS_DESC) ||
                             word_is(awaddr_r, `DMACS_OFS_DEBUG)) ? 2'h0 : 2'h2;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   function automatic logic wr_hit(input logic [11:0] ofs);
      wr_hit = wr_fire && word_is(awaddr_r, ofs);
   endfunction

   assign sel        = info_r[20:16];
   assign req_bit    = (sel == 5'h00) ? 1'b1 : req_s2_r[sel];
   assign waitwr_bit = (state_r == DMACS_DRAIN);
   assign paused_bit = !ctrl_r[`DMACS_B_RUN] || xfer_waiting || halt_s2_r ||
                       (ctrl_r[`DMACS_B_DRAIN] && outs_r > `DMACS_MAX_OUTS);
   assign stall_bit  = (state_r == DMACS_XFER) && !paused_bit && !req_bit &&
                       (info_r[`DMACS_INFO_SRCREQ] || info_r[`DMACS_INFO_DSTREQ]);
   assign chain_end  = (state_r == DMACS_LINK) && (next_descriptor_link_r == 32'h00000000);
   assign done_set   = (state_r == DMACS_LINK);
   assign irq_set    = done_set && info_r[`DMACS_INFO_IEN];
   assign fetch_idx  = widx_r + {2'h0, cb_valid && (state_r == DMACS_FETCH)};

   // Channel sequencer
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         state_r                <= DMACS_IDLE;
         widx_r                 <= 3'h0;
         info_r                 <= 32'h00000000;
         next_descriptor_link_r <= 32'h00000000;
         loaded_r               <= 1'b0;
      end
      else
         case (state_r)
            DMACS_IDLE:
               if (ctrl_r[`DMACS_B_RUN] && descriptor_pointer_r != 32'h00000000)
               begin
                  state_r <= DMACS_FETCH;
                  widx_r  <= 3'h0;
               end
            DMACS_FETCH:
               if (cb_valid)
               begin
                  if (widx_r == 3'h0)
                     info_r <= cb_data;
                  if (widx_r == 3'h6)
                     next_descriptor_link_r <= cb_data;
                  widx_r <= widx_r + 3'h1;
                  if (widx_r == `DMACS_CB_WORDS - 3'h1)
                  begin
                     state_r  <= DMACS_XFER;
                     loaded_r <= 1'b1;
                  end
               end
            DMACS_XFER:
               if (xfer_done)
                  state_r <= ctrl_r[`DMACS_B_DRAIN] ? DMACS_DRAIN : DMACS_LINK;
            DMACS_DRAIN:
               // Completion is held back until every write has been answered
               if (outs_r == 5'h00)
                  state_r <= DMACS_LINK;
            DMACS_LINK:
            begin
               widx_r  <= 3'h0;
               state_r <= (next_descriptor_link_r == 32'h00000000) ? DMACS_IDLE : DMACS_FETCH;
            end
            default:
               state_r <= DMACS_IDLE;
         endcase
   end

   // Outstanding write tally
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
         outs_r <= 5'h00;
      else if (wr_issue && !wr_resp && outs_r != 5'h1F)
         outs_r <= outs_r + 5'h01;
      else if (!wr_issue && wr_resp && outs_r != 5'h00)
         outs_r <= outs_r - 5'h01;
   end

   // Control, flags and descriptor pointer
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         ctrl_r               <= 32'h00000000;
         done_r               <= 1'b0;
         irq_r                <= 1'b0;
         dbg_r                <= 8'h00;
         descriptor_pointer_r <= `DMACS_DESC_RESET;
      end
      else
      begin
         if (wr_hit(`DMACS_OFS_CTRL))
            ctrl_r <= wdata_r & `DMACS_CTRL_WMASK;
         if (chain_end)
            ctrl_r[`DMACS_B_RUN] <= 1'b0;
         // Setting wins over a simultaneous write-one clear
         done_r <= done_set || (done_r && !(wr_hit(`DMACS_OFS_CTRL) && wdata_r[`DMACS_B_DONE]));
         irq_r  <= irq_set || (irq_r && !(wr_hit(`DMACS_OFS_CTRL) && wdata_r[`DMACS_B_IRQ]));
         dbg_r  <= dbg_err_set | (dbg_r & ~(wr_hit(`DMACS_OFS_DEBUG) ? wdata_r[7:0] : 8'h00));
         if (done_set)
            descriptor_pointer_r <= next_descriptor_link_r;
         else if (wr_hit(`DMACS_OFS_DESC) && state_r == DMACS_IDLE)
            descriptor_pointer_r <= wdata_r;
      end
   end

   // Read side
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= 2'h0;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case ({s_axi_araddr[11:2], 2'h0})
               `DMACS_OFS_CTRL:
                  s_axi_rdata <= (ctrl_r & `DMACS_CTRL_WMASK)
                     | (32'(|dbg_r) << `DMACS_B_ERROR)
                     | (32'(waitwr_bit) << `DMACS_B_WAITWR)
                     | (32'(stall_bit) << `DMACS_B_STALL)
                     | (32'(paused_bit) << `DMACS_B_PAUSED)
                     | (32'(req_bit && loaded_r) << `DMACS_B_REQ)
                     | (32'(irq_r) << `DMACS_B_IRQ)
                     | (32'(done_r) << `DMACS_B_DONE);
               `DMACS_OFS_DESC:  s_axi_rdata <= descriptor_pointer_r;
               `DMACS_OFS_DEBUG: s_axi_rdata <= {24'h000000, dbg_r};
               `DMACS_OFS_INFO:  s_axi_rdata <= info_r;
               `DMACS_OFS_NEXT:  s_axi_rdata <= next_descriptor_link_r;
               default:
               begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Memory, engine and priority outputs
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         cb_req    <= 1'b0;
         descriptor_pointer   <= 32'h00000000;
         xfer_go   <= 1'b0;
         axi_qos   <= 4'h0;
         cb_info_o <= 32'h00000000;
      end
      else
      begin
         cb_req    <= (state_r == DMACS_FETCH) && !(cb_valid && widx_r == `DMACS_CB_WORDS - 3'h1);
         // Index after this beat, so the address never lags a word behind
         // Low five bits assumed zero by alignment of every block
         descriptor_pointer   <= descriptor_pointer_r + {27'h0, fetch_idx, 2'h0};
         // A stalled channel must really hold its data, not only report it
         xfer_go   <= (state_r == DMACS_XFER) && !paused_bit && !stall_bit && !xfer_done;
         axi_qos   <= pan_s2_r[sel] ? ctrl_r[23:20] : ctrl_r[19:16];
         cb_info_o <= info_r;
      end
   end
endmodule

// >>> testbench/dmacs_mem_model.sv
/*
 Memory and data engine stand-in: answers descriptor reads every other
 cycle, ends a block after a count of go cycles. Assumes the bench fills mem.
*/
`timescale 1ns/1ps
module dmacs_mem_model
#(
   parameter int XFER_CYCLES = 7
)
(
   input wire logic        core_clk,
   input wire logic        reset_n,
   input wire logic        cb_req,
   input wire logic [31:0] descriptor_pointer,
   output logic            cb_valid,
   output logic [31:0]     cb_data,
   input wire logic        xfer_go,
   output logic            xfer_done
);
   logic [31:0] mem [logic [31:0]];
   int          go_cnt;
   // Slow answers on purpose; idle data toggles so stale words never look valid
   always_ff @(posedge core_clk)
   begin
      cb_valid <= reset_n && cb_req && !cb_valid;
      cb_data <= (cb_req && !cb_valid) ? mem[descriptor_pointer] : ~cb_data;
   end
   // A pause holds the count, so a resumed block finishes its remaining cycles
   always_ff @(posedge core_clk)
   begin
      xfer_done <= reset_n && xfer_go && !xfer_done && go_cnt == XFER_CYCLES - 1;
      go_cnt <= (!reset_n || xfer_done) ? 0 : go_cnt + (xfer_go ? 1 : 0);
   end
endmodule

// >>> testbench/dmacs_props.sv
/*
 Checker on dmacs_top ports: descriptor fetch, chain link and pausing.
 Assumes the bind at the foot of this file.
*/
`timescale 1ns/1ps
module dmacs_props
(
   input wire logic        core_clk,
   input wire logic        reset_n,
   input wire logic        cb_req,
   input wire logic [31:0] descriptor_pointer,
   input wire logic        cb_valid,
   input wire logic [31:0] cb_data,
   input wire logic        xfer_go,
   input wire logic        xfer_done,
   input wire logic        xfer_waiting,
   input wire logic        debug_halt,
   input wire logic [31:0] cb_info_o
);
   logic [2:0]  cnt_r;
   logic [31:0] link_r;
   logic [31:0] info_r;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // Beat count restarts whenever a fetch ends
   always_ff @(posedge core_clk)
      cnt_r <= (!reset_n || !cb_req) ? 3'h0 : cnt_r + {2'h0, cb_valid};
   always_ff @(posedge core_clk)
      if (cb_valid && cnt_r == 3'h0)
         info_r <= cb_data;
   always_ff @(posedge core_clk)
      if (cb_valid && cnt_r == 3'h6)
         link_r <= cb_data;
   sequence s_link_fetch;
      ##[1:60] (cb_req && descriptor_pointer == link_r);
   endsequence
   sequence s_no_fetch;
      ##1 !cb_req [*8];
   endsequence
   a_fetch_before_go: assert property (cb_req |-> !xfer_go)
      else $error("data moved during descriptor fetch");
   a_fetch_at_ptr: assert property ($rose(cb_req) |-> descriptor_pointer[4:0] == 5'h00)
      else $error("fetch did not start at the block base");
   a_fetch_beats: assert property ($fell(cb_req) |-> cnt_r == 3'h7)
      else $error("fetch ended without seven words");
   a_info_loaded: assert property ($fell(cb_req) |-> ##1 cb_info_o == info_r)
      else $error("loaded info differs from word zero");
   a_next_fetch: assert property (xfer_done && link_r != 32'h0 |-> s_link_fetch)
      else $error("next block not fetched from link");
   a_zero_link_stop: assert property (xfer_done && link_r == 32'h0 |-> s_no_fetch)
      else $error("fetch after zero link");
   a_halt_pauses: assert property (debug_halt [*5] |-> !xfer_go)
      else $error("data moved during debug halt");
   a_wait_pauses: assert property (xfer_waiting [*3] |-> !xfer_go)
      else $error("data moved during wait cycles");
endmodule
bind dmacs_top dmacs_props u_props (.core_clk, .reset_n, .cb_req, .descriptor_pointer, .cb_valid, .cb_data,
   .xfer_go, .xfer_done, .xfer_waiting, .debug_halt, .cb_info_o);

// >>> testbench/dmacs_top_test.sv
/*
 Bench for dmacs_top: AXI4-Lite register access, a two-block chain, pause,
 resume, error and drain mode. Assumes the memory model and bound checker.
*/
`timescale 1ns/1ps
`include "dmacs_defs.svh"
module dmacs_top_test;
   logic        core_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        xfer_waiting = 1'b0, wr_issue = 1'b0, wr_resp = 1'b0, debug_halt = 1'b0;
   logic [7:0]  dbg_err_set = 8'h00;
   logic [31:0] peripheral_request_line = 32'h0, periph_panic = 32'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        cb_req, cb_valid, xfer_go, xfer_done;
   logic [1:0]  s_axi_bresp, s_axi_rresp, br;
   logic [31:0] s_axi_rdata, descriptor_pointer, cb_data, cb_info_o, d;
   logic [3:0]  axi_qos;
   int          errors = 0, compares = 0;
   localparam logic [11:0] CT = `DMACS_OFS_CTRL;
   localparam logic [11:0] DS = `DMACS_OFS_DESC;
   dmacs_top uut (.core_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .cb_req, .descriptor_pointer, .cb_valid, .cb_data, .xfer_go, .xfer_done, .xfer_waiting,
      .wr_issue, .wr_resp, .dbg_err_set, .peripheral_request_line, .periph_panic, .debug_halt,
      .axi_qos, .cb_info_o);
   dmacs_mem_model mem_m (.core_clk, .reset_n, .cb_req, .descriptor_pointer, .cb_valid, .cb_data, .xfer_go,
      .xfer_done);
   always #2 core_clk = ~core_clk;
   task automatic test_done;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end
      while (!s_axi_bvalid && n < 50);
      br = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 50) begin errors++; test_done(); end
      @(posedge core_clk);
   endtask
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end
      while (!s_axi_rvalid && n < 50);
      v = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 50) begin errors++; test_done(); end
      @(posedge core_clk);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
      logic [1:0] r;
      axi_rd(a, d, r);
      chk(d & m, exp);
   endtask
   // Polls the control word; the bound stands in for any hang of the chain
   task automatic wait_ctrl(input logic [31:0] m, input logic [31:0] v);
      logic [1:0] r;
      int n;
      n = 0;
      do begin axi_rd(CT, d, r); n++; end while ((d & m) !== v && n < 100);
      if (n >= 100) begin errors++; test_done(); end
   endtask
   task automatic put_cb(input logic [31:0] b, input logic [31:0] info, input logic [31:0] nxt);
      for (int i = 0; i < 7; i++)
         mem_m.mem[b + 32'(4 * i)] = (i == 0) ? info : (i == 6) ? nxt : 32'h0;
   endtask
   initial
   begin
      logic [1:0] r;
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      put_cb(32'h100, 32'h00050401, 32'h200);
      put_cb(32'h200, 32'h0, 32'h0);
      put_cb(32'h300, 32'h0, 32'h0);
      rc(CT, 32'hFFFFFFEF, 32'h0);
      rc(DS, 32'hFFFFFFFF, 32'h0);
      axi_rd(12'h008, d, r);
      chk({30'h0, r}, 32'h2);
      axi_wr(`DMACS_OFS_INFO, 32'hFFFFFFFF);
      chk({30'h0, br}, 32'h2);
      rc(`DMACS_OFS_INFO, 32'hFFFFFFFF, 32'h0);
      axi_wr(CT, 32'h0F93FEE0);
      chk({30'h0, br}, 32'h0);
      rc(CT, 32'hFFFFFFEF, 32'h00930000);
      chk({28'h0, axi_qos}, 32'h3);
      axi_wr(CT, 32'h00930001);
      repeat (10) @(posedge core_clk);
      chk({31'h0, cb_req}, 32'h0);
      axi_wr(DS, 32'h100);
      wait_ctrl(32'h38, 32'h20);
      rc(DS, 32'hFFFFFFFF, 32'h100);
      rc(`DMACS_OFS_INFO, 32'hFFFFFFFF, 32'h00050401);
      periph_panic[5] <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk({28'h0, axi_qos}, 32'h9);
      periph_panic[5] <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk({28'h0, axi_qos}, 32'h3);
      debug_halt <= 1'b1;
      peripheral_request_line[5] <= 1'b1;
      repeat (6) @(posedge core_clk);
      rc(CT, 32'hFFFFFFFF, 32'h00930019);
      axi_wr(CT, 32'h00930000);
      debug_halt <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk({31'h0, xfer_go}, 32'h0);
      rc(CT, 32'h11, 32'h10);
      xfer_waiting <= 1'b1;
      axi_wr(CT, 32'h00930001);
      repeat (4) @(posedge core_clk);
      chk({31'h0, xfer_go}, 32'h0);
      xfer_waiting <= 1'b0;
      wait_ctrl(32'h1, 32'h0);
      rc(CT, 32'hFFFFFFEF, 32'h0093000E);
      rc(DS, 32'hFFFFFFFF, 32'h0);
      axi_wr(CT, 32'h00930004);
      rc(CT, 32'hFFFFFFEF, 32'h0093000A);
      axi_wr(CT, 32'h00930002);
      rc(CT, 32'hFFFFFFEF, 32'h00930008);
      dbg_err_set <= 8'h04;
      @(posedge core_clk);
      dbg_err_set <= 8'h00;
      rc(CT, 32'h100, 32'h100);
      axi_wr(`DMACS_OFS_DEBUG, 32'h4);
      rc(CT, 32'h100, 32'h0);
      axi_wr(DS, 32'h300);
      axi_wr(CT, 32'h10930001);
      // Fourteen writes in flight is one over the drain limit
      wr_issue <= 1'b1;
      repeat (14) @(posedge core_clk);
      wr_issue <= 1'b0;
      rc(CT, 32'h51, 32'h11);
      wr_resp <= 1'b1;
      repeat (13) @(posedge core_clk);
      wr_resp <= 1'b0;
      wait_ctrl(32'h41, 32'h41);
      wr_resp <= 1'b1;
      @(posedge core_clk);
      wr_resp <= 1'b0;
      wait_ctrl(32'h41, 32'h0);
      test_done();
   end
endmodule
